/* File: mst_pkg.sv */
// How it works
// - the linearization enable and point enable are each a 0/1 setting, both reset to 0.
// - motion detect and zero tracking times take only 0 to 99, in tenths of a second.
// - data output select 0 outputs the held value and select 1 outputs the live input.
// - of the two moving-average settings, the one written last is the one applied.
// - an accepted write to one moving-average setting forces the other to zero.
// - settings live in volatile storage; a reload returns the saved copy, updated only by save-all and set to defaults by reset.
// - a value outside the legal set of its command is ignored and the setting is kept.
//
// Purpose: constants and types of the measurement setting table
// Assumes: 32-bit classic wishbone, byte addressed registers four bytes apart
// Notes: setting tables are indexed by entry number
package mst_pkg;
  localparam int MST_N = 22;

  localparam logic [7:0] MST_ADR_CMD = 8'h00;
  localparam logic [7:0] MST_ADR_DATA = 8'h04;
  localparam logic [7:0] MST_ADR_STAT = 8'h08;

  localparam int MST_STAT_REJ = 0;
  localparam int MST_STAT_UNK = 1;
  localparam int MST_STAT_SAVED = 2;

  localparam logic [15:0] MST_CMD_SAVE = 16'd5003;
  localparam logic signed [31:0] MST_SAVE_KEY = 32'sd90;

  localparam int MST_IX_LIN_EN = 0;
  localparam int MST_IX_AVG_SEL = 11;
  localparam int MST_IX_AVG_DIR = 13;
  localparam int MST_IX_MOT_TIME = 14;
  localparam int MST_IX_ZT_TIME = 16;
  localparam int MST_IX_DATA_SEL = 21;

  localparam int MST_TIME_MAX = 99;
  localparam int MST_AVG_BASE = 16;

  localparam int MST_CMD [MST_N] = '{1200, 1201, 1202, 1203, 1204, 1205, 1402, 1403,
    1404, 1405, 2001, 2002, 2003, 2004, 2101, 2102, 2201, 2202, 2301, 2302, 2303, 2401};
  localparam int MST_MIN [MST_N] = '{0, 1, 0, 1, -99999, -99999, 0, 0,
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, -19999, 0};
  localparam int MST_MAX [MST_N] = '{1, 3, 1, 9999, 99999, 99999, 3, 3,
    99999, 1, 6, 8, 1, 2048, 99, 999, 99, 999, 1, 99999, 19999, 1};
  localparam int MST_DEF [MST_N] = '{0, 1, 0, 1, 0, 0, 0, 0,
    11000, 0, 4, 0, 1, 0, 15, 5, 0, 0, 1, 99999, 0, 0};

  typedef struct packed {
    logic data_sel;
    logic avg_direct;
    logic [11:0] avg_size;
    logic [6:0] motion_time;
    logic [6:0] zt_time;
  } mst_applied_t;
endpackage

/* File: mst_cell.sv */
// Purpose: one setting entry with volatile and saved copies
// Assumes: min, max and default given per entry
// Notes: reload has priority over a write in the same cycle
`timescale 1ns/1ps
module mst_cell #(
  parameter int MIN = 0,
  parameter int MAX = 1,
  parameter int DEF = 0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic signed [31:0] wdata,
  input wire logic clr_off,
  input wire logic save,
  input wire logic reload,
  output logic ok,
  output logic signed [31:0] value_r,
  output logic signed [31:0] saved_r
);
  assign ok = (wdata >= MIN) && (wdata <= MAX);

  always_ff @(posedge clk) begin
    if (reset) begin
      value_r <= DEF;
    end else if (reload) begin
      value_r <= saved_r;
    end else if (clr_off) begin
      value_r <= '0;
    end else if (wr_en && ok) begin
      value_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      saved_r <= DEF;
    end else if (save) begin
      saved_r <= value_r;
    end
  end
endmodule

/* File: mst_wb_slave.sv */
// Purpose: classic wishbone handshake and address decode
// Assumes: master holds the request until it sees ack
// Notes: ack comes one cycle after the request and lasts one cycle
`timescale 1ns/1ps
module mst_wb_slave (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  output logic ack_r,
  output logic start,
  output logic fire,
  output logic sel_cmd,
  output logic sel_data,
  output logic sel_stat
);
  import mst_pkg::*;

  wire req = wb_cyc_i && wb_stb_i;

  assign start = req && !ack_r;
  assign fire = req && ack_r;
  assign sel_cmd = wb_adr_i == MST_ADR_CMD;
  assign sel_data = wb_adr_i == MST_ADR_DATA;
  assign sel_stat = wb_adr_i == MST_ADR_STAT;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= start;
    end
  end
endmodule

/* File: mst_top.sv */
// Purpose: command numbered setting store reached over wishbone
// Assumes: held and live values come from logic on the same clock
// Notes: reload models the power cycle that restores saved settings
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module mst_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reload,
  input wire logic signed [31:0] held_value,
  input wire logic signed [31:0] live_value,
  output logic signed [31:0] data_out,
  output mst_pkg::mst_applied_t applied,
  output logic [31:0] setting_vals [mst_pkg::MST_N]
);
  import mst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // bus front end

  logic start;
  logic fire;
  logic sel_cmd;
  logic sel_data;
  logic sel_stat;

  mst_wb_slave u_wb (
    .clk(clk),
    .reset(reset),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_adr_i(wb_adr_i),
    .ack_r(wb_ack_o),
    .start(start),
    .fire(fire),
    .sel_cmd(sel_cmd),
    .sel_data(sel_data),
    .sel_stat(sel_stat)
  );

  logic [15:0] cmd_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [31:0] dat_o_r;
  logic avg_direct_r;
  logic avg_direct_nxt;
  logic signed [31:0] data_out_r;
  mst_applied_t applied_r;
  mst_applied_t applied_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // setting entries

  logic signed [31:0] vals [MST_N];
  logic signed [31:0] saved [MST_N];
  logic [MST_N-1:0] hit;
  logic [MST_N-1:0] ok;
  logic [MST_N-1:0] clr;
  logic signed [31:0] cur_val;
  logic signed [31:0] wdata;

  wire wr_data = fire && wb_we_i && sel_data;
  wire wr_cmd = fire && wb_we_i && sel_cmd;
  wire wr_stat = fire && wb_we_i && sel_stat;
  wire hit_any = |hit;
  wire is_save = cmd_r == MST_CMD_SAVE;
  wire ok_sel = |(hit & ok);
  wire accept = wr_data && hit_any && ok_sel;
  wire rejected = wr_data && hit_any && !ok_sel;
  wire save_go = wr_data && is_save && (wdata == MST_SAVE_KEY);
  wire save_bad = wr_data && is_save && (wdata != MST_SAVE_KEY);
  wire unknown = wr_data && !hit_any && !is_save;
  wire acc_sel = accept && hit[MST_IX_AVG_SEL];
  wire acc_dir = accept && hit[MST_IX_AVG_DIR];

  genvar g;
  generate
    for (g = 0; g < MST_N; g++) begin : g_cell
      assign hit[g] = cmd_r == 16'(MST_CMD[g]);
      assign setting_vals[g] = vals[g];
      mst_cell #(
        .MIN(MST_MIN[g]),
        .MAX(MST_MAX[g]),
        .DEF(MST_DEF[g])
      ) u_cell (
        .clk(clk),
        .reset(reset),
        .wr_en(wr_data && hit[g]),
        .wdata(wdata),
        .clr_off(clr[g]),
        .save(save_go),
        .reload(reload),
        .ok(ok[g]),
        .value_r(vals[g]),
        .saved_r(saved[g])
      );
    end
  endgenerate

  // the other moving-average setting drops to off
  always_comb begin
    clr = '0;
    clr[MST_IX_AVG_DIR] = acc_sel;
    clr[MST_IX_AVG_SEL] = acc_dir;
  end

  // read mux and byte merge against the addressed value
  always_comb begin
    cur_val = '0;
    for (int i = 0; i < MST_N; i++) begin
      if (hit[i]) begin
        cur_val = vals[i];
      end
    end
  end

  always_comb begin
    wdata = cur_val;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        wdata[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command, status and read data

  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~wb_dat_i[2:0];
    end
    if (rejected || save_bad) begin
      stat_nxt[MST_STAT_REJ] = 1'b1;
    end
    if (unknown) begin
      stat_nxt[MST_STAT_UNK] = 1'b1;
    end
    if (save_go) begin
      stat_nxt[MST_STAT_SAVED] = 1'b1;
    end
  end

  wire [31:0] rd_mux = sel_cmd ? {16'h0000, cmd_r} :
                       sel_data ? cur_val :
                       sel_stat ? {29'h0000000, stat_r} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_r <= 16'h0000;
      stat_r <= 3'h0;
      dat_o_r <= 32'h00000000;
    end else begin
      if (wr_cmd) begin
        cmd_r <= (cmd_r & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) |
                 (wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
      end
      stat_r <= stat_nxt;
      if (start) begin
        dat_o_r <= rd_mux;
      end
    end
  end

  assign wb_dat_o = dat_o_r;

  ////////////////////////////////////////////////////////////////////////////////
  // settings applied to the measurement path

  always_comb begin
    avg_direct_nxt = avg_direct_r;
    // a reload restores the mode of whichever setting comes back non-zero
    if (reload) begin
      avg_direct_nxt = saved[MST_IX_AVG_SEL] == 0;
    end else if (acc_dir) begin
      avg_direct_nxt = 1'b1;
    end else if (acc_sel) begin
      avg_direct_nxt = 1'b0;
    end
  end

  wire [3:0] avg_code = vals[MST_IX_AVG_SEL][3:0];
  wire [11:0] avg_from_sel = (avg_code == 4'h0) ? 12'h000 :
                             12'(MST_AVG_BASE << (avg_code - 4'h1));
  wire [11:0] avg_from_dir = (vals[MST_IX_AVG_DIR] < 2) ? 12'h000 :
                             vals[MST_IX_AVG_DIR][11:0];

  always_comb begin
    applied_nxt.data_sel = vals[MST_IX_DATA_SEL][0];
    applied_nxt.avg_direct = avg_direct_nxt;
    applied_nxt.avg_size = avg_direct_r ? avg_from_dir : avg_from_sel;
    applied_nxt.motion_time = vals[MST_IX_MOT_TIME][6:0];
    applied_nxt.zt_time = vals[MST_IX_ZT_TIME][6:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avg_direct_r <= 1'b0;
      applied_r <= '0;
      data_out_r <= '0;
    end else begin
      avg_direct_r <= avg_direct_nxt;
      applied_r <= applied_nxt;
      data_out_r <= vals[MST_IX_DATA_SEL][0] ? live_value : held_value;
    end
  end

  assign applied = applied_r;
  assign data_out = data_out_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  ack_follow_a: assert property (start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack did not follow the request");

  reject_keep_a: assert property (rejected && !reload |=> $stable(cur_val))
    else $error("illegal value changed a setting");

  accept_store_a: assert property (
    accept && !reload && !(hit[MST_IX_AVG_SEL] && acc_dir) |=> cur_val == $past(wdata))
    else $error("accepted value not read back");

  avg_clear_dir_a: assert property (acc_sel && !reload |=> vals[MST_IX_AVG_DIR] == 0)
    else $error("direct set size not forced off");

  avg_clear_sel_a: assert property (acc_dir && !reload |=> vals[MST_IX_AVG_SEL] == 0)
    else $error("set size selection not forced off");

  avg_latest_a: assert property (acc_dir && !reload |=> avg_direct_r ##1 applied.avg_direct)
    else $error("latest moving-average setting not applied");

  data_held_a: assert property (
    vals[MST_IX_DATA_SEL] == 0 |=> data_out == $past(held_value))
    else $error("held value not output");

  data_live_a: assert property (
    vals[MST_IX_DATA_SEL] == 1 |=> data_out == $past(live_value))
    else $error("live input not output");

  time_range_a: assert property (
    vals[MST_IX_MOT_TIME] <= MST_TIME_MAX && vals[MST_IX_ZT_TIME] <= MST_TIME_MAX)
    else $error("time setting out of range");

  lin_bit_a: assert property (vals[MST_IX_LIN_EN] inside {0, 1} && vals[2] inside {0, 1})
    else $error("linearization enable not 0 or 1");

  reload_back_a: assert property (
    reload |=> vals[MST_IX_MOT_TIME] == $past(saved[MST_IX_MOT_TIME]))
    else $error("reload did not restore saved value");

  // status flags and saved copies
  stat_rej_a: assert property (rejected || save_bad |=> stat_r[MST_STAT_REJ])
    else $error("rejected write did not flag status");

  stat_unk_a: assert property (unknown |=> stat_r[MST_STAT_UNK])
    else $error("unknown command did not flag status");

  unknown_keep_a: assert property (
    unknown && !reload |=> $stable(vals[MST_IX_MOT_TIME]))
    else $error("unknown command changed a setting");

  stat_saved_a: assert property (save_go |=> stat_r[MST_STAT_SAVED])
    else $error("save did not flag status");

  save_copy_a: assert property (
    save_go |=> saved[MST_IX_MOT_TIME] == $past(vals[MST_IX_MOT_TIME]))
    else $error("save did not copy the live value");

  save_hold_a: assert property (!save_go |=> $stable(saved[MST_IX_MOT_TIME]))
    else $error("saved copy changed without save");

  // applied settings follow the table one edge later
  time_copy_a: assert property (
    1'b1 |=> applied.motion_time == $past(vals[MST_IX_MOT_TIME][6:0]) &&
    applied.zt_time == $past(vals[MST_IX_ZT_TIME][6:0]))
    else $error("time settings not applied");

  sel_copy_a: assert property (
    1'b1 |=> applied.data_sel == $past(vals[MST_IX_DATA_SEL][0]))
    else $error("data output selection not applied");

  avg_off_a: assert property (
    vals[MST_IX_AVG_SEL] == 0 && vals[MST_IX_AVG_DIR] < 2 |=> applied.avg_size == 0)
    else $error("moving average not off");

  avg_dir_size_a: assert property (
    avg_direct_r && vals[MST_IX_AVG_DIR] > 1 |=>
    applied.avg_size == $past(vals[MST_IX_AVG_DIR][11:0]))
    else $error("direct set size not applied");

  // bus side stays quiet between requests
  cmd_keep_a: assert property (!wr_cmd |=> $stable(cmd_r))
    else $error("command changed without a write");

  dat_stand_a: assert property (!start |=> $stable(wb_dat_o))
    else $error("read data changed between requests");

  unmapped_zero_a: assert property (
    start && !(sel_cmd || sel_data || sel_stat) |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

/* File: mst_wbm.sv */
// Purpose: classic wishbone master standing in for the fieldbus master
// Assumes: the slave answers every request with one ack pulse
// Notes: a caller starts a transfer right after a rising edge
`timescale 1ns/1ps
module mst_wbm (
  input wire logic clk,
  input wire logic ack,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    dat = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // request held until ack is seen; released data shows its inverse
  task automatic xfer_s(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d;
    @(posedge clk);
  endtask
  // full-word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    xfer_s(w, a, d, 4'hf);
  endtask
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench of the measurement setting table
// Assumes: read results are noted in a queue before the read starts
// Notes: data output is checked against the random inputs in each cycle out of reset with a steady select
`timescale 1ns/1ps
module tb_top;
  import mst_pkg::*;
  logic clk, reset, reload, cyc, stb, we, ack, pr;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, ph, pl, ps, pps;
  logic signed [31:0] held, live, dout;
  mst_applied_t app;
  logic [31:0] vals [MST_N];
  logic [31:0] expq [$];
  int errors = 0;
  int compares = 0;
  integer seed = 72;
  int v;
  // rated output stays at its default of 3000 in this bench
  int rated_out = 3000;
  mst_top dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .reload(reload), .held_value(held), .live_value(live), .data_out(dout),
    .applied(app), .setting_vals(vals));
  mst_wbm bus (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(dat_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic put(input int c, input int d);
    bus.xfer(1'b1, MST_ADR_CMD, 32'(c));
    bus.xfer(1'b1, MST_ADR_DATA, 32'(d));
  endtask
  task automatic get(input int c, input int d);
    bus.xfer(1'b1, MST_ADR_CMD, 32'(c));
    expq.push_back(32'(d));
    bus.xfer(1'b0, MST_ADR_DATA, 32'h0);
  endtask
  task automatic stat(input logic [31:0] s);
    expq.push_back(s);
    bus.xfer(1'b0, MST_ADR_STAT, 32'h0);
    bus.xfer(1'b1, MST_ADR_STAT, 32'h7);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    held <= $random(seed);
    live <= $random(seed);
    if (ack === 1'b1 && we === 1'b0) begin
      chk(dat_o, expq.pop_front());
    end
    if (reset === 1'b0 && pr === 1'b0 && ps === pps) begin
      chk(dout, ps[0] ? pl : ph);
    end
    pr <= reset;
    ph <= held;
    pl <= live;
    ps <= vals[MST_IX_DATA_SEL];
    pps <= ps;
  end
  initial begin
    #(100 * 20000);
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    reload = 1'b0;
    held = 0;
    live = 0;
    pr = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < MST_N; i++) begin
      chk(vals[i], 32'(MST_DEF[i]));
    end
    // out of range both ways is refused, the upper bound itself is taken
    for (int i = 0; i < MST_N; i++) begin
      put(MST_CMD[i], MST_MAX[i] + 1);
      put(MST_CMD[i], MST_MIN[i] - 1);
      chk(vals[i], 32'(MST_DEF[i]));
      put(MST_CMD[i], MST_MAX[i]);
      get(MST_CMD[i], MST_MAX[i]);
    end
    stat(32'h1);
    chk(32'(app.motion_time), 32'd99);
    chk(32'(app.zt_time), 32'd99);
    chk(32'(app.data_sel), 32'd1);
    // a byte-lane write merges with the stored value
    bus.xfer(1'b1, MST_ADR_CMD, 32'd1404);
    bus.xfer_s(1'b1, MST_ADR_DATA, 32'hffffff00, 4'h1);
    get(1404, 32'h00018600);
    put(2401, 0);
    put(2002, 3);
    @(posedge clk);
    chk(vals[MST_IX_AVG_DIR], 32'h0);
    chk(32'(app.avg_size), 32'(MST_AVG_BASE << 2));
    chk(32'(app.data_sel), 32'd0);
    put(2004, 100);
    @(posedge clk);
    chk(vals[MST_IX_AVG_SEL], 32'h0);
    chk({app.avg_direct, 31'(app.avg_size)}, 32'h80000064);
    expq.push_back(32'h0);
    bus.xfer(1'b0, 8'h0c, 32'h0);
    put(1234, 5);
    get(1234, 0);
    expq.push_back(32'd1234);
    bus.xfer(1'b0, MST_ADR_CMD, 32'h0);
    stat(32'h2);
    put(2101, 7);
    put(5003, 91);
    put(5003, 90);
    stat(32'h5);
    put(2101, 8);
    reload <= 1'b1;
    @(posedge clk);
    reload <= 1'b0;
    @(posedge clk);
    get(2101, 7);
    get(2004, 100);
    v = $unsigned($random(seed)) % 100000;
    put(1404, v);
    get(1404, v);
    put(1203, 1 + v % (rated_out - 1));
    get(1203, 1 + v % (rated_out - 1));
    // a reset in mid-run brings both copies back to their defaults
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reload <= 1'b1;
    @(posedge clk);
    reload <= 1'b0;
    @(posedge clk);
    get(2101, MST_DEF[MST_IX_MOT_TIME]);
    get(2004, MST_DEF[MST_IX_AVG_DIR]);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
